/* File: design/shms_top.sv */
// Power-up port mode selection for the host serial port
`timescale 1ns/1ps
module shms_top #(
	parameter int unsigned SAMPLE_CYC = shms_pkg::SAMPLE_CYC,
	parameter int unsigned READY_CYC = shms_pkg::READY_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic port_select_or_chip_select_pin,
	input wire logic serial_clk_pin,
	input wire logic i2c_addressed,
	input wire logic core_byte_ready,
	output logic pullup_en_q,
	output logic i2c_mode_q,
	output logic spi_mode_q,
	output logic port_ready_q,
	output logic spi_cs_b_q,
	output logic serial_clk_o_q,
	output logic serial_clk_oe_b_q,
	output shms_pkg::shms_status_t status_q
);
	logic sel_m_q;
	logic sel_s_q;
	logic sck_m_q;
	logic sck_s_q;
	logic sck_d_q;
	logic [shms_pkg::CNT_W-1:0] cnt_q;
	logic [shms_pkg::CNT_W-1:0] cnt_d;
	shms_pkg::shms_state_t state_q;
	shms_pkg::shms_state_t state_d;
	logic mode_q;
	logic mode_d;
	logic sample_now;
	logic ready_now;
	logic stretch;
	logic sck_fall;
	logic run_d;
	logic i2c_d;
	logic spi_d;
	logic cs_d;
	shms_pkg::shms_status_t status_d;

	// One port mode is active only in the run state and only for the latched choice
	function automatic logic mode_active(
		input shms_pkg::shms_state_t st,
		input logic m,
		input logic want
	);
		return (st == shms_pkg::SHMS_RUN) && (m == want);
	endfunction : mode_active

	// Pins from outside the clock domain pass two flops first
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sel_m_q <= 1'b1;
			sel_s_q <= 1'b1;
		end
		else if (clk_en)
		begin
			sel_m_q <= port_select_or_chip_select_pin;
			sel_s_q <= sel_m_q;
		end
	end

	// Reset to the idle-high level so no false falling edge follows reset
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sck_m_q <= 1'b1;
			sck_s_q <= 1'b1;
			sck_d_q <= 1'b1;
		end
		else if (clk_en)
		begin
			sck_m_q <= serial_clk_pin;
			sck_s_q <= sck_m_q;
			sck_d_q <= sck_s_q;
		end
	end

	assign sck_fall = sck_d_q & ~sck_s_q;
	// 1 ms wait leaves the pull-up time to settle the pin before sampling
	assign sample_now = (state_q == shms_pkg::SHMS_INIT) &&
		(cnt_q == shms_pkg::CNT_W'(SAMPLE_CYC - 1));
	assign ready_now = (state_q == shms_pkg::SHMS_WAIT) &&
		(cnt_q == shms_pkg::CNT_W'(READY_CYC - 1));
	// Low on the pin picks I2C, high picks SPI; held until reset
	assign mode_d = sample_now ? sel_s_q : mode_q;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			shms_pkg::SHMS_INIT:
				if (sample_now)
					state_d = shms_pkg::SHMS_WAIT;
			shms_pkg::SHMS_WAIT:
				if (ready_now)
					state_d = shms_pkg::SHMS_RUN;
			shms_pkg::SHMS_RUN:
				state_d = shms_pkg::SHMS_RUN;
			default:
				state_d = shms_pkg::SHMS_INIT;
		endcase
	end

	// Stretch from the first falling edge seen while the core lags; release when ready.
	// Stretch starts a few cycles after the host edge because of the synchroniser.
	assign stretch = port_ready_q && (mode_q == shms_pkg::MODE_I2C) && i2c_addressed &&
		!core_byte_ready && (sck_fall || !serial_clk_oe_b_q);

	// Next values of the outputs, decoded once
	assign run_d = (state_d == shms_pkg::SHMS_RUN);
	assign i2c_d = mode_active(state_d, mode_d, shms_pkg::MODE_I2C);
	assign spi_d = mode_active(state_d, mode_d, shms_pkg::MODE_SPI);
	// Chip select only follows the pin once SPI is in force
	assign cs_d = spi_d ? sel_s_q : 1'b1;
	assign cnt_d = (state_d != state_q || state_q == shms_pkg::SHMS_RUN) ? '0 :
		cnt_q + 1'b1;
	assign status_d = '{ready: run_d, spi_mode: spi_d, i2c_mode: i2c_d, pullup_en: !run_d};

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= shms_pkg::SHMS_INIT;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q <= '0;
		end
		else if (clk_en)
		begin
			cnt_q <= cnt_d;
		end
	end

	// Defaults to SPI until the sample, matching the pull-up level
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_q <= shms_pkg::MODE_SPI;
		end
		else if (clk_en)
		begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pullup_en_q <= 1'b1;
		end
		else if (clk_en)
		begin
			pullup_en_q <= !run_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			i2c_mode_q <= 1'b0;
		end
		else if (clk_en)
		begin
			i2c_mode_q <= i2c_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			spi_mode_q <= 1'b0;
		end
		else if (clk_en)
		begin
			spi_mode_q <= spi_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			port_ready_q <= 1'b0;
		end
		else if (clk_en)
		begin
			port_ready_q <= run_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			spi_cs_b_q <= 1'b1;
		end
		else if (clk_en)
		begin
			spi_cs_b_q <= cs_d;
		end
	end

	// Open drain: the line is only ever pulled low, the enable does the work
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			serial_clk_o_q <= 1'b0;
		end
		else if (clk_en)
		begin
			serial_clk_o_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			serial_clk_oe_b_q <= 1'b1;
		end
		else if (clk_en)
		begin
			serial_clk_oe_b_q <= ~stretch;
		end
	end

	// Status mirrors the single outputs, pull-up bit included from reset on
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			status_q <= '{ready: 1'b0, spi_mode: 1'b0, i2c_mode: 1'b0, pullup_en: 1'b1};
		end
		else if (clk_en)
		begin
			status_q <= status_d;
		end
	end
endmodule : shms_top

/* File: design/shms_pkg.sv */
// Constants and carrier types for the serial host mode selector
package shms_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned SAMPLE_MIN_MS = 1;
	localparam int unsigned SAMPLE_MAX_MS = 10;
	localparam int unsigned READY_MAX_MS = 20;
	// Sample at the earliest legal point, cycle count rounded down
	localparam int unsigned SAMPLE_CYC = (CLK_HZ / 1000) * SAMPLE_MIN_MS;
	localparam int unsigned SAMPLE_LATEST_CYC = (CLK_HZ / 1000) * SAMPLE_MAX_MS;
	localparam int unsigned READY_CYC = (CLK_HZ / 1000) * READY_MAX_MS;
	localparam int unsigned CNT_W = 20;
	localparam logic MODE_I2C = 1'b0;
	localparam logic MODE_SPI = 1'b1;

	typedef enum logic [1:0] {
		SHMS_INIT = 2'b00,
		SHMS_WAIT = 2'b01,
		SHMS_RUN = 2'b11
	} shms_state_t;

	typedef struct packed {
		logic ready;
		logic spi_mode;
		logic i2c_mode;
		logic pullup_en;
	} shms_status_t;
endpackage : shms_pkg

/* File: tb/shms_checker.sv */
// Port checks for the mode selector
`timescale 1ns/1ps
module shms_checker (
	input wire logic sys_clk, rst_b, i2c_addressed, core_byte_ready, pullup_en_q,
	input wire logic i2c_mode_q, spi_mode_q, port_ready_q, spi_cs_b_q, serial_clk_oe_b_q
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_one_mode: assert property (!(i2c_mode_q && spi_mode_q)) else $error("two modes");
	a_ready_mode: assert property ($rose(port_ready_q) |-> i2c_mode_q ^ spi_mode_q)
		else $error("no mode");
	a_pullup_init: assert property (pullup_en_q != port_ready_q) else $error("pullup");
	a_cs_idle: assert property (!spi_mode_q |-> spi_cs_b_q) else $error("cs");
	a_mode_hold: assert property (port_ready_q |=> $stable(spi_mode_q)) else $error("mode");
	a_ready_held: assert property (port_ready_q |=> port_ready_q) else $error("ready");
	a_stretch_cause: assert property ($fell(serial_clk_oe_b_q) |->
		$past(i2c_addressed & i2c_mode_q & !core_byte_ready)) else $error("stretch");
	a_stretch_end: assert property (core_byte_ready |=> serial_clk_oe_b_q) else $error("hold");
	cover property ($rose(i2c_mode_q));
	cover property ($rose(spi_mode_q));
	cover property ($fell(serial_clk_oe_b_q));
endmodule : shms_checker
bind shms_top shms_checker i_shms_checker (.*);

/* File: tb/shms_host.sv */
// Host model for the select pin and serial clock
`timescale 1ns/1ps
module shms_host (
	input wire logic sel, cs_b, pu, run,
	output logic pin, scl
);
	// Clock idles high between frames, as a real host leaves it
	initial scl = 1'b1;
	// Bench rate is scaled; only idle-high and stopping between frames matter here
	always #160 scl = run ? ~scl : 1'b1;
	assign pin = sel ? 1'b0 : (pu ? 1'b1 : cs_b);
endmodule : shms_host

/* File: tb/tb_top.sv */
// Bench for the mode selector
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 0, rst_b = 0, sel = 0, cs_b = 1, run = 0, adr = 0, rdy = 0;
	logic pin, scl, pu, i2c, spi, prdy, csb, oeb, sco;
	logic [3:0] st;
	int errors = 0, tests_run = 0, cyc = 0;
	shms_host i_shms_host (.sel, .cs_b, .pu, .run, .pin, .scl);
	shms_top #(.SAMPLE_CYC(8), .READY_CYC(16)) i_shms_top (.sys_clk, .rst_b, .clk_en(1'b1),
		.port_select_or_chip_select_pin(pin), .serial_clk_pin(scl & oeb), .i2c_addressed(adr),
		.core_byte_ready(rdy), .pullup_en_q(pu), .i2c_mode_q(i2c), .spi_mode_q(spi),
		.port_ready_q(prdy), .spi_cs_b_q(csb), .serial_clk_o_q(sco), .serial_clk_oe_b_q(oeb),
		.status_q(st));
	initial forever #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (++cyc == 400) begin errors++; print_verdict(); end
	task automatic w(input int n); repeat (n) @(negedge sys_clk); endtask : w
	task automatic chk(input logic got, exp);
		tests_run++;
		if (got !== exp) begin errors++; $display("mismatch %0t output", $time); end
	endtask : chk
	task automatic boot(input logic i2c_sel);
		rst_b = 0; sel = i2c_sel; w(5);
		chk(st[0], 1'b1);
		rst_b = 1; w(20);
		chk(pu, 1'b1);
		chk(st[0], 1'b1);
		chk(prdy, 1'b0);
		chk(st[3], 1'b0);
		w(10);
		chk(pu, 1'b0);
		chk(prdy, 1'b1);
		chk(i2c, i2c_sel);
		chk(spi, !i2c_sel);
		chk(st[3], 1'b1);
		chk(st[2], !i2c_sel);
		chk(st[1], i2c_sel);
		chk(st[0], 1'b0);
		chk(sco, 1'b0);
	endtask : boot
	task automatic t_spi;
		boot(1'b0);
		cs_b = 0; w(5);
		chk(csb, 1'b0);
		sel = 1; w(5);
		chk(spi, 1'b1);
		$display("spi test done");
	endtask : t_spi
	task automatic t_i2c;
		boot(1'b1);
		sel = 0; adr = 1; run = 1; w(20);
		chk(i2c, 1'b1);
		chk(csb, 1'b1);
		chk(oeb, 1'b0);
		chk(sco, 1'b0);
		rdy = 1; w(2);
		chk(oeb, 1'b1);
		$display("i2c test done");
	endtask : t_i2c
	initial
	begin
		t_spi();
		t_i2c();
		print_verdict();
	end
	task automatic print_verdict;
		$display("tests_run %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
endmodule : tb_top
